// *** hw/tcw_pkg.sv ***
package tcw_pkg;
  // Register port addresses (byte registers)
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CMP_LOW = 2'h1;
  localparam logic [1:0] ADDR_CMP_HIGH = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // Control field positions
  localparam int CTL_RUN_BIT = 5;
  localparam int CTL_SRC_MSB = 4;
  localparam int CTL_SRC_LSB = 2;
  localparam int CTL_MODE_BIT = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h3d;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  // Source clock codes
  localparam logic [2:0] SRC_TAP_A = 3'h0;
  localparam logic [2:0] SRC_TAP_B = 3'h1;
  localparam logic [2:0] SRC_TAP_C = 3'h2;
  localparam logic [2:0] SRC_TAP_D = 3'h3;
  localparam logic [2:0] SRC_HF = 3'h4;
  localparam logic [2:0] SRC_LF = 3'h5;
  localparam logic [2:0] SRC_PIN = 3'h7;
  // Divider tap positions (edge = carry out of bit n-1)
  localparam int TAP_HF_23 = 23;
  localparam int TAP_HF_13 = 13;
  localparam int TAP_HF_8 = 8;
  localparam int TAP_HF_3 = 3;
  localparam int TAP_LF_15 = 15;
  localparam int TAP_LF_5 = 5;
  localparam int CMP_COARSE_LSB = 11;
endpackage : tcw_pkg

// *** hw/tcw_sync.sv ***
`timescale 1ns/1ps
module tcw_sync (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : tcw_sync

// *** hw/tcw_timer.sv ***
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Start 0 halts and clears counter; start 1 runs it.
// - Normal divider, codes 000..011 fc taps, 101 fs, 111 pin, 110 reserved.
// - Option bit or slow/sleep: 000 fs/2^15, 001 fs/2^5; 100 fc in slow mode two.
// - Mode bit 0 timer or event counter, 1 window mode.
// - Compare updates after low byte then high byte write; in slow mode two with fc, a lone high byte write updates the upper byte.
// - Old compare value used between low and high byte writes.
// - Control bits 7, 6, 1 read undefined; here they read zero.
// - Entering stop mode clears start field and halts counter.
// - Timer mode counts internal clock; match interrupts, clears, resumes.
// - Fc source in slow mode two matches upper five compare bits only.
// - Event mode counts rising pin edges, resuming after match clear.
// - Event mode match detection on falling pin edge.
// - Window mode counts internal clock edges while pin high; match interrupts.
// - Timer mode with fc or fs can time oscillator warm-up.
module tcw_timer
  import tcw_pkg::*;
#(
  parameter int HF_DIV_BITS = 24,
  parameter int LF_DIV_BITS = 16
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic hf_tick_in,
  input wire logic lf_tick_in,
  input wire logic divider_option_bit_in,
  input wire logic slow_mode_in,
  input wire logic slow_mode_two_in,
  input wire logic stop_mode_in,
  input wire logic external_count_pin_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic match_interrupt_out,
  output logic running_out
);
  logic [7:0] counter_control;
  logic [15:0] compare_value;
  logic [7:0] compare_value_low;
  logic low_pending;
  logic [15:0] count;
  logic [HF_DIV_BITS-1:0] hf_div;
  logic [LF_DIV_BITS-1:0] lf_div;
  logic pin_sync;
  logic pin_prev;
  logic stop_prev;
  logic src_tick;
  logic next_src_tick;
  logic pin_rise;
  logic pin_fall;
  logic run;
  logic window_mode;
  logic coarse_match;
  logic match_hit;
  logic inc_en;
  logic [2:0] src;

  tcw_sync u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in(external_count_pin_in),
    .sync_out(pin_sync)
  );

  assign run = counter_control[CTL_RUN_BIT];
  assign window_mode = counter_control[CTL_MODE_BIT];
  assign src = counter_control[CTL_SRC_MSB:CTL_SRC_LSB];
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // Returns 1 on the tick where a divider's low n bits wrap to zero
  function automatic logic tap_edge(input logic [31:0] div, input int n, input logic tick);
    tap_edge = tick && ((div & ((32'h1 << n) - 32'h1)) == ((32'h1 << n) - 32'h1));
  endfunction : tap_edge

  // Free running prescalers; the counter taps them so it never has its own clock
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hf_div <= '0;
    end else if (hf_tick_in) begin
      hf_div <= hf_div + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lf_div <= '0;
    end else if (lf_tick_in) begin
      lf_div <= lf_div + 1'b1;
    end
  end

  always_comb begin
    logic low_rate;
    logic [31:0] hf_w;
    logic [31:0] lf_w;
    low_rate = divider_option_bit_in | slow_mode_in;
    hf_w = 32'(hf_div);
    lf_w = 32'(lf_div);
    next_src_tick = 1'b0;
    unique case (src)
      SRC_TAP_A: next_src_tick = low_rate ? tap_edge(lf_w, TAP_LF_15, lf_tick_in)
                                          : tap_edge(hf_w, TAP_HF_23, hf_tick_in);
      SRC_TAP_B: next_src_tick = low_rate ? tap_edge(lf_w, TAP_LF_5, lf_tick_in)
                                          : tap_edge(hf_w, TAP_HF_13, hf_tick_in);
      SRC_TAP_C: next_src_tick = !slow_mode_in && tap_edge(hf_w, TAP_HF_8, hf_tick_in);
      SRC_TAP_D: next_src_tick = !slow_mode_in && tap_edge(hf_w, TAP_HF_3, hf_tick_in);
      SRC_HF: next_src_tick = slow_mode_two_in && hf_tick_in;
      SRC_LF: next_src_tick = !slow_mode_in && lf_tick_in;
      default: next_src_tick = 1'b0; // Reserved and pin codes give no internal clock
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_tick <= 1'b0;
      pin_prev <= 1'b0;
      stop_prev <= 1'b0;
    end else begin
      src_tick <= next_src_tick;
      pin_prev <= pin_sync;
      stop_prev <= stop_mode_in;
    end
  end

  // Coarse compare for fc warm-up in slow mode two
  assign coarse_match = (src == SRC_HF) && slow_mode_two_in;
  assign match_hit = coarse_match ?
    (count[15:CMP_COARSE_LSB] == compare_value[15:CMP_COARSE_LSB]) :
    (count == compare_value);

  always_comb begin
    inc_en = 1'b0;
    if (src == SRC_PIN) begin
      inc_en = window_mode ? 1'b0 : pin_rise;
    end else if (window_mode) begin
      inc_en = src_tick && pin_sync;
    end else begin
      inc_en = src_tick;
    end
  end

  // Counter and match
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
      match_interrupt_out <= 1'b0;
    end else begin
      match_interrupt_out <= 1'b0;
      if (!run) begin
        count <= '0;
      end else if ((src == SRC_PIN) && !window_mode) begin
        // Event mode checks on the falling edge so the count shows one full pulse
        if (pin_fall && match_hit) begin
          count <= '0;
          match_interrupt_out <= 1'b1;
        end else if (inc_en) begin
          count <= count + 16'h0001;
        end
      end else if (inc_en) begin
        if (match_hit) begin
          count <= '0;
          match_interrupt_out <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

  // Control register; stop entry wins over a simultaneous software write
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      counter_control <= CONTROL_RESET;
    end else begin
      if (wr_in && addr_in == ADDR_CONTROL) begin
        counter_control <= wdata_in & CTL_WRITE_MASK;
      end
      if (stop_mode_in && !stop_prev) begin
        counter_control[CTL_RUN_BIT] <= 1'b0;
      end
    end
  end

  // Compare register, ordered byte pair
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      compare_value <= COMPARE_RESET;
      compare_value_low <= '0;
      low_pending <= 1'b0;
    end else if (wr_in && addr_in == ADDR_CMP_LOW) begin
      compare_value_low <= wdata_in;
      low_pending <= 1'b1;
    end else if (wr_in && addr_in == ADDR_CMP_HIGH) begin
      low_pending <= 1'b0;
      if (low_pending) begin
        compare_value <= {wdata_in, compare_value_low};
      end else if (coarse_match) begin
        compare_value[15:8] <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        ADDR_CONTROL: rdata_out <= counter_control;
        ADDR_CMP_LOW: rdata_out <= compare_value[7:0];
        ADDR_CMP_HIGH: rdata_out <= compare_value[15:8];
        ADDR_STATUS: rdata_out <= {6'h00, low_pending, run};
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      running_out <= 1'b0;
    end else begin
      running_out <= run;
    end
  end
endmodule : tcw_timer

// *** tb/tcw_pin_model.sv ***
`timescale 1ns/1ps
module tcw_pin_model (
  input wire logic clk_sys_in,
  input wire logic fire_in,
  input wire logic [7:0] pulses_in,
  input wire logic [7:0] width_in,
  output logic pin_out
);
  initial pin_out = 1'b0;
  // Bench keeps widths at three clocks or more, above the two-flop sync
  always begin
    do @(posedge clk_sys_in); while (fire_in !== 1'b1);
    repeat (pulses_in) begin
      pin_out <= 1'b1;
      repeat (width_in) @(posedge clk_sys_in);
      pin_out <= 1'b0;
      repeat (width_in) @(posedge clk_sys_in);
    end
  end
endmodule : tcw_pin_model

// *** tb/tcw_timer_props.sv ***
`timescale 1ns/1ps
module tcw_timer_props
  import tcw_pkg::*;
#(
  parameter int HF_DIV_BITS = 24,
  parameter int LF_DIV_BITS = 16
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic stop_mode_in,
  input wire logic external_count_pin_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic match_interrupt_out,
  input wire logic running_out
);
  logic evt;
  logic [5:0] hist;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Mode is only visible through control writes, so track it here
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      evt <= 1'b0;
      hist <= 6'h00;
    end else begin
      hist <= {hist[4:0], external_count_pin_in};
      if (wr_in && addr_in == ADDR_CONTROL) begin
        evt <= wdata_in[4:2] == SRC_PIN && !wdata_in[CTL_MODE_BIT];
      end
    end
  end
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_ctl_rd; rd_in && addr_in == ADDR_CONTROL |=> rdata_out[7:6] == 2'h0 && !rdata_out[1]
    && rdata_out[CTL_RUN_BIT] == $past(running_out); endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read bits wrong");
  property p_stat_rd; rd_in && addr_in == ADDR_STATUS |=> rdata_out[0] == $past(running_out); endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status run bit wrong");
  property p_stop_wr; wr_in && addr_in == ADDR_CONTROL && !wdata_in[CTL_RUN_BIT]
    |-> ##[1:2] !running_out; endproperty
  a_stop_wr: assert property (p_stop_wr) else $error("stop write ignored");
  property p_stop_mode; $rose(stop_mode_in) |-> ##[1:3] !running_out; endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop mode kept run");
  property p_irq_one; match_interrupt_out |=> !match_interrupt_out; endproperty
  a_irq_one: assert property (p_irq_one) else $error("interrupt longer than one cycle");
  property p_idle_quiet; !running_out && !$past(running_out) && !$past(running_out, 2)
    |-> !match_interrupt_out; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("interrupt while stopped");
  property p_evt_fall; match_interrupt_out && evt |-> (hist[5:3] & ~hist[4:2]) != 3'h0; endproperty
  a_evt_fall: assert property (p_evt_fall) else $error("event match off pin fall");
endmodule : tcw_timer_props
bind tcw_timer tcw_timer_props #(.HF_DIV_BITS(HF_DIV_BITS), .LF_DIV_BITS(LF_DIV_BITS)) u_props (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .stop_mode_in(stop_mode_in),
  .external_count_pin_in(external_count_pin_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .match_interrupt_out(match_interrupt_out), .running_out(running_out));

// *** tb/tb_tcw_timer.sv ***
`timescale 1ns/1ps
module tb_tcw_timer;
  logic clk_sys_in, rstn_in, hf, lf, opt, slow, slow_mode_two, stop, pin, wr_in, rd_in, fire, irq, run;
  logic [1:0] addr_in, ph;
  logic [7:0] wdata_in, rdata_out, pulses, width;
  int mismatches, samples_checked, irqs;
  tcw_timer uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .hf_tick_in(hf), .lf_tick_in(lf),
    .divider_option_bit_in(opt), .slow_mode_in(slow), .slow_mode_two_in(slow_mode_two),
    .stop_mode_in(stop), .external_count_pin_in(pin), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .match_interrupt_out(irq),
    .running_out(run));
  tcw_pin_model pm (.clk_sys_in(clk_sys_in), .fire_in(fire), .pulses_in(pulses),
    .width_in(width), .pin_out(pin));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // High ticks every 2 clocks, low ticks every 4
  always @(posedge clk_sys_in) begin
    ph <= ph + 2'h1;
    hf <= ph[0];
    lf <= &ph;
    if (irq === 1'b1) irqs++;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input string s);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(s, e, rdata_out);
  endtask : rd
  task automatic to_irq(output int c);
    c = 0;
    do begin @(negedge clk_sys_in); c++; end while (irq !== 1'b1 && c < 3000);
  endtask : to_irq
  task automatic period(input int e, input string s);
    int c;
    to_irq(c);
    to_irq(c);
    chk(s, e, c);
  endtask : period
  task automatic pulse_run(input int n, input int w, input int hold);
    pulses <= n;
    width <= w;
    fire <= 1'b1;
    @(posedge clk_sys_in);
    fire <= 1'b0;
    repeat (hold) @(posedge clk_sys_in);
  endtask : pulse_run
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    {hf, lf, opt, slow, slow_mode_two, stop, wr_in, rd_in, fire, ph, addr_in} = '0;
    {wdata_in, pulses, width, irqs, mismatches, samples_checked} = '0;
    rstn_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(0, 8'h00, "ctl_reset");
    rd(2, 8'hff, "cmp_reset");
    wr(3, 8'hff);
    wr(0, 8'hff);
    rd(0, 8'h3d, "ctl_mask");
    rd(3, 8'h01, "status_run");
    wr(0, 8'h0c);
    wr(1, 8'h02);
    wr(2, 8'h00);
    wr(0, 8'h2c);
    period(48, "per_cmp2");
    wr(1, 8'h05);
    period(48, "per_low_only");
    wr(2, 8'h00);
    period(96, "per_cmp5");
    wr(2, 8'h01);
    period(96, "per_high_only");
    wr(0, 8'h0c);
    irqs = 0;
    repeat (200) @(posedge clk_sys_in);
    chk("stopped_irqs", 0, irqs);
    wr(0, 8'h2c);
    stop <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk("stop_run", 0, run);
    rd(0, 8'h0c, "stop_ctl");
    stop <= 1'b0;
    wr(0, 8'h1c);
    wr(1, 8'h03);
    wr(2, 8'h00);
    wr(0, 8'h3c);
    irqs = 0;
    pulse_run(5, 4, 70);
    chk("evt_irqs", 1, irqs);
    wr(0, 8'h1c);
    wr(0, 8'h0d);
    wr(0, 8'h2d);
    irqs = 0;
    repeat (300) @(posedge clk_sys_in);
    chk("win_low", 0, irqs);
    pulse_run(1, 200, 450);
    chk("win_high", 1, irqs >= 2);
    wr(0, 8'h0d);
    wr(0, 8'h14);
    wr(0, 8'h34);
    period(16, "per_lf");
    wr(0, 8'h14);
    slow <= 1'b1;
    wr(0, 8'h04);
    wr(0, 8'h24);
    period(512, "per_slow");
    wr(0, 8'h04);
    slow_mode_two <= 1'b1;
    wr(0, 8'h10);
    // Upper five compare bits at 2, the smallest legal warm-up value
    wr(2, 8'h10);
    rd(2, 8'h10, "coarse_high");
    wr(0, 8'h30);
    irqs = 0;
    repeat (8300) @(posedge clk_sys_in);
    chk("coarse_irqs", 1, irqs);
    close_out;
  end
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    mismatches++;
    close_out;
  end
endmodule : tb_tcw_timer
